//--- common/pfmux_pkg.sv
/*
  constants, types and state codes for the pad function mux of pads one
  to six. assumes a single 100 MHz clock and an active-low async reset.
*/
package pfmux_pkg;
  localparam int NPAD = 6;
  localparam int ENC_W = 4;
  localparam int ADC_CH_DEF = 4;
  localparam logic [3:0] ENC_GPIO = 4'h0;
  localparam logic [3:0] ENC_I2C_LO = 4'h1;
  localparam logic [3:0] ENC_PWM = 4'h3;
  localparam logic [3:0] ENC_BCLK = 4'h3;
  localparam logic [3:0] ENC_CAM = 4'h4;
  localparam logic [3:0] ENC_I2C_HI = 4'h5;
  localparam logic [3:0] ENC_CARD = 4'h6;
  localparam logic [3:0] ENC_UART = 4'h7;
  localparam logic [3:0] ENC_SPI = 4'h7;
  localparam logic [3:0] ENC_CARD_D0 = 4'h8;
  localparam logic [3:0] ENC_CAP = 4'hc;
  localparam logic [3:0] ENC_CAP_P6 = 4'hd;
  localparam logic [3:0] ENC_FSYNC = 4'hd;
  localparam logic [1:0] CLS_FREE = 2'h0;
  localparam logic [1:0] CLS_HOLD1 = 2'h1;
  localparam logic [1:0] CLS_HOLD0 = 2'h2;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic OSC_RUN_LEVEL = 1'b1;
  localparam logic ANT_ON = 1'b1;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_RUN = 4'h2,
    ST_SLEEP = 4'h4,
    ST_HIB = 4'h8
  } pfmux_state_t;

  // signals the peripherals present towards the pads
  typedef struct packed {
    logic [5:0] gpio_o;
    logic [5:0] gpio_oe;
    logic timer_pwm_out_a;
    logic timer_pwm_out_b;
    logic first_serial_transmit;
    logic second_serial_transmit;
    logic card_clock_out;
    logic card_cmd_o;
    logic card_cmd_oe;
    logic card_d0_o;
    logic card_d0_oe;
    logic camera_pixel_clock_out;
    logic audio_bit_clock;
    logic audio_frame_sync;
    logic scl_low;
    logic sda_low;
    logic spi_clk_o;
    logic spi_clk_oe;
    logic spi_so_o;
    logic spi_so_oe;
  } pfmux_po_t;

  // signals the pads return to the peripherals
  typedef struct packed {
    logic [5:0] gpio_i;
    logic [5:0] capture_i;
    logic scl_i;
    logic sda_i;
    logic first_serial_receive;
    logic second_serial_receive;
    logic card_cmd_i;
    logic card_d0_i;
    logic camera_vertical_sync;
    logic camera_horizontal_sync;
    logic camera_data_bit_four;
    logic camera_data_bit_five;
    logic spi_clk_i;
    logic spi_so_i;
  } pfmux_pi_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic [1:0] cls;
    logic hit;
  } pfmux_drv_t;
endpackage

//--- design/pfmux_top.sv
/*
  pad function mux for pads one to six, antenna select pads, oscillator
  enable / boot-mode pad, slow crystal sensing and ADC switch control.
  assumes all pad and peripheral inputs are synchronous to clk and that
  the board resolves pad levels from the output enables.
*/
`timescale 1ns/100ps
module pfmux_top #(
  parameter int ADC_CH = pfmux_pkg::ADC_CH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // per-pad encoding fields
  input wire logic [5:0][3:0] mux_sel,
  // power state requests
  input wire logic deep_sleep_state,
  input wire logic hibernate_mode,
  output pfmux_pkg::pfmux_state_t power_state_q,
  // peripheral side
  input wire pfmux_pkg::pfmux_po_t periph_out,
  output pfmux_pkg::pfmux_pi_t periph_in_q,
  // pads one to six
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out_q,
  output logic [5:0] pad_oe_q,
  // antenna select pads
  input wire logic antenna_sel,
  output logic [1:0] ant_pad_out_q,
  output logic [1:0] ant_pad_oe_q,
  // oscillator enable and boot-mode pad
  input wire logic osc_pad_in,
  output logic osc_pad_out_q,
  output logic osc_pad_oe_q,
  output logic osc_pad_pd_q,
  output logic boot_mode_sense_bit_two_q,
  // slow crystal negative pad
  input wire logic slow_crystal_negative_pad_in,
  input wire logic xn_gpio_out,
  input wire logic xn_gpio_oe,
  output logic slow_clk_ext_q,
  output logic xn_pad_out_q,
  output logic xn_pad_oe_q,
  // ADC analog switches
  input wire logic [ADC_CH-1:0] adc_sw_req,
  output logic [ADC_CH-1:0] adc_sw_close_q
);
  logic [5:0][3:0] sel_q;
  pfmux_pkg::pfmux_drv_t [5:0] drv;
  pfmux_pkg::pfmux_pi_t pi_d;

  generate
    if (ADC_CH < 1 || ADC_CH > 8) begin : g_bad_adc
      $error("ADC_CH must be 1 to 8");
    end
  endgenerate

  function automatic logic on(input int p, input logic [3:0] e);
    on = (sel_q[p] == e);
  endfunction

  function automatic pfmux_pkg::pfmux_drv_t mk(input logic o,
      input logic oe, input logic [1:0] cls);
    mk = '{o: o, oe: oe, cls: cls, hit: 1'b1};
  endfunction

  // open-drain: only ever pulls low
  function automatic pfmux_pkg::pfmux_drv_t od(input logic low);
    od = mk(1'b0, low, pfmux_pkg::CLS_FREE);
  endfunction

  function automatic pfmux_pkg::pfmux_drv_t route(input int p,
      input logic [3:0] e, input pfmux_pkg::pfmux_po_t po);
    pfmux_pkg::pfmux_drv_t r;
    pfmux_pkg::pfmux_drv_t inp;
    r = '0;
    inp = mk(1'b0, 1'b0, pfmux_pkg::CLS_FREE);
    if (e == pfmux_pkg::ENC_GPIO) begin
      r = mk(po.gpio_o[p], po.gpio_oe[p], pfmux_pkg::CLS_FREE);
    end else begin
      case (p)
        0: begin
          case (e)
            pfmux_pkg::ENC_I2C_LO: r = od(po.scl_low);
            pfmux_pkg::ENC_PWM:
              r = mk(po.timer_pwm_out_a, 1'b1, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CARD:
              r = mk(po.card_clock_out, 1'b1, pfmux_pkg::CLS_HOLD0);
            pfmux_pkg::ENC_UART:
              r = mk(po.second_serial_transmit, 1'b1,
                pfmux_pkg::CLS_HOLD1);
            pfmux_pkg::ENC_CAP: r = inp;
            default: r = '0;
          endcase
        end
        1: begin
          case (e)
            pfmux_pkg::ENC_I2C_LO: r = od(po.sda_low);
            pfmux_pkg::ENC_PWM:
              r = mk(po.timer_pwm_out_b, 1'b1, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CAM:
              r = mk(po.camera_pixel_clock_out, 1'b1,
                pfmux_pkg::CLS_HOLD0);
            pfmux_pkg::ENC_CARD:
              r = mk(1'b0, po.card_cmd_oe & ~po.card_cmd_o,
                pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_UART: r = inp;
            pfmux_pkg::ENC_CAP: r = inp;
            pfmux_pkg::ENC_FSYNC:
              r = mk(po.audio_frame_sync, 1'b1, pfmux_pkg::CLS_FREE);
            default: r = '0;
          endcase
        end
        2: begin
          case (e)
            pfmux_pkg::ENC_BCLK:
              r = mk(po.audio_bit_clock, 1'b1, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CAM: r = inp;
            pfmux_pkg::ENC_I2C_HI: r = od(po.scl_low);
            pfmux_pkg::ENC_UART:
              r = mk(po.first_serial_transmit, 1'b1,
                pfmux_pkg::CLS_HOLD1);
            pfmux_pkg::ENC_CAP: r = inp;
            default: r = '0;
          endcase
        end
        3: begin
          case (e)
            pfmux_pkg::ENC_CAM: r = inp;
            pfmux_pkg::ENC_I2C_HI: r = od(po.sda_low);
            pfmux_pkg::ENC_UART: r = inp;
            pfmux_pkg::ENC_CAP: r = inp;
            default: r = '0;
          endcase
        end
        4: begin
          case (e)
            pfmux_pkg::ENC_CAM: r = inp;
            pfmux_pkg::ENC_I2C_HI: r = od(po.scl_low);
            pfmux_pkg::ENC_SPI:
              r = mk(po.spi_clk_o, po.spi_clk_oe, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CAP: r = inp;
            default: r = '0;
          endcase
        end
        5: begin
          case (e)
            pfmux_pkg::ENC_CAM: r = inp;
            pfmux_pkg::ENC_I2C_HI: r = od(po.sda_low);
            pfmux_pkg::ENC_SPI:
              r = mk(po.spi_so_o, po.spi_so_oe, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CARD_D0:
              r = mk(po.card_d0_o, po.card_d0_oe, pfmux_pkg::CLS_FREE);
            pfmux_pkg::ENC_CAP_P6: r = inp;
            default: r = '0;
          endcase
        end
        default: r = '0;
      endcase
    end
    route = r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= {6{pfmux_pkg::SEL_RST}};
    end else begin
      sel_q <= mux_sel;
    end
  end

  // hibernate outranks deep sleep; boot lasts one cycle for the straps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state_q <= pfmux_pkg::ST_BOOT;
    end else begin
      case (power_state_q)
        pfmux_pkg::ST_BOOT: power_state_q <= pfmux_pkg::ST_RUN;
        default: begin
          if (hibernate_mode) begin
            power_state_q <= pfmux_pkg::ST_HIB;
          end else if (deep_sleep_state) begin
            power_state_q <= pfmux_pkg::ST_SLEEP;
          end else begin
            power_state_q <= pfmux_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // straps caught while the oscillator pad is still released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_mode_sense_bit_two_q <= 1'b0;
      slow_clk_ext_q <= 1'b0;
    end else if (power_state_q == pfmux_pkg::ST_BOOT) begin
      boot_mode_sense_bit_two_q <= osc_pad_in;
      slow_clk_ext_q <= slow_crystal_negative_pad_in;
    end
  end

  // freed pad is output-only so the sensing is never fooled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xn_pad_out_q <= 1'b0;
      xn_pad_oe_q <= 1'b0;
    end else begin
      xn_pad_out_q <= xn_gpio_out & slow_clk_ext_q;
      xn_pad_oe_q <= xn_gpio_oe & slow_clk_ext_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_pad_out_q <= 1'b0;
      osc_pad_oe_q <= 1'b0;
      osc_pad_pd_q <= 1'b1;
    end else begin
      case (power_state_q)
        pfmux_pkg::ST_BOOT, pfmux_pkg::ST_HIB: begin
          osc_pad_out_q <= 1'b0;
          osc_pad_oe_q <= 1'b0;
          osc_pad_pd_q <= 1'b1;
        end
        default: begin
          osc_pad_out_q <= pfmux_pkg::OSC_RUN_LEVEL;
          osc_pad_oe_q <= 1'b1;
          osc_pad_pd_q <= 1'b0;
        end
      endcase
    end
  end

  // one pad per antenna, never muxed with anything else
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ant_pad_out_q <= 2'h0;
      ant_pad_oe_q <= 2'h0;
    end else begin
      ant_pad_out_q <= {antenna_sel, ~antenna_sel};
      ant_pad_oe_q <= {2{pfmux_pkg::ANT_ON}};
    end
  end

  // digital path stays live; software tristates it before closing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_sw_close_q <= '0;
    end else begin
      adc_sw_close_q <= adc_sw_req;
    end
  end

  always_comb begin
    for (int p = 0; p < pfmux_pkg::NPAD; p++) begin
      drv[p] = route(p, sel_q[p], periph_out);
    end
  end

  // reset gives hi-z; hibernate passes the routed drive through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 6'h00;
      pad_oe_q <= 6'h00;
    end else begin
      for (int p = 0; p < pfmux_pkg::NPAD; p++) begin
        if (power_state_q == pfmux_pkg::ST_SLEEP &&
            drv[p].cls == pfmux_pkg::CLS_HOLD1) begin
          pad_out_q[p] <= 1'b1;
          pad_oe_q[p] <= 1'b1;
        end else if (power_state_q == pfmux_pkg::ST_SLEEP &&
            drv[p].cls == pfmux_pkg::CLS_HOLD0) begin
          pad_out_q[p] <= 1'b0;
          pad_oe_q[p] <= 1'b1;
        end else begin
          pad_out_q[p] <= drv[p].o;
          pad_oe_q[p] <= drv[p].oe;
        end
      end
    end
  end

  // unselected inputs read zero
  always_comb begin
    pi_d = '0;
    for (int p = 0; p < pfmux_pkg::NPAD; p++) begin
      pi_d.gpio_i[p] = pad_in[p] & on(p, pfmux_pkg::ENC_GPIO);
      pi_d.capture_i[p] = pad_in[p] & on(p, (p == 5) ?
        pfmux_pkg::ENC_CAP_P6 : pfmux_pkg::ENC_CAP);
    end
    pi_d.scl_i = (pad_in[0] & on(0, pfmux_pkg::ENC_I2C_LO)) |
      (pad_in[2] & on(2, pfmux_pkg::ENC_I2C_HI)) |
      (pad_in[4] & on(4, pfmux_pkg::ENC_I2C_HI));
    pi_d.sda_i = (pad_in[1] & on(1, pfmux_pkg::ENC_I2C_LO)) |
      (pad_in[3] & on(3, pfmux_pkg::ENC_I2C_HI)) |
      (pad_in[5] & on(5, pfmux_pkg::ENC_I2C_HI));
    pi_d.second_serial_receive = pad_in[1] & on(1, pfmux_pkg::ENC_UART);
    pi_d.first_serial_receive = pad_in[3] & on(3, pfmux_pkg::ENC_UART);
    pi_d.card_cmd_i = pad_in[1] & on(1, pfmux_pkg::ENC_CARD);
    pi_d.card_d0_i = pad_in[5] & on(5, pfmux_pkg::ENC_CARD_D0);
    pi_d.camera_vertical_sync = pad_in[2] & on(2, pfmux_pkg::ENC_CAM);
    pi_d.camera_horizontal_sync = pad_in[3] & on(3, pfmux_pkg::ENC_CAM);
    pi_d.camera_data_bit_four = pad_in[4] & on(4, pfmux_pkg::ENC_CAM);
    pi_d.camera_data_bit_five = pad_in[5] & on(5, pfmux_pkg::ENC_CAM);
    pi_d.spi_clk_i = pad_in[4] & on(4, pfmux_pkg::ENC_SPI);
    pi_d.spi_so_i = pad_in[5] & on(5, pfmux_pkg::ENC_SPI);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_in_q <= '0;
    end else begin
      periph_in_q <= pi_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_boot;
    power_state_q == pfmux_pkg::ST_BOOT;
  endsequence

  sequence s_osc_on;
    osc_pad_oe_q && osc_pad_out_q && !osc_pad_pd_q;
  endsequence

  AST_ANT_DEDICATED: assert property (
    1'b1 |=> ant_pad_oe_q == 2'h3 &&
      ant_pad_out_q == {$past(antenna_sel), !$past(antenna_sel)})
    else $error("antenna pads not following select");
  AST_OSC_UP: assert property (s_boot |-> ##[1:2] s_osc_on)
    else $error("oscillator pad not driven high after boot");
  AST_OSC_HIB: assert property (
    power_state_q == pfmux_pkg::ST_HIB |=>
      !osc_pad_oe_q && osc_pad_pd_q)
    else $error("oscillator pad driven in hibernate");
  AST_STRAP: assert property (
    s_boot |-> !osc_pad_oe_q ##1
      boot_mode_sense_bit_two_q == $past(osc_pad_in))
    else $error("boot mode not sampled from released pad");
  AST_XTAL: assert property (
    s_boot |=> slow_clk_ext_q == $past(slow_crystal_negative_pad_in))
    else $error("crystal sense not captured at boot");
  AST_XN_FREE: assert property (
    !slow_clk_ext_q |=> !xn_pad_oe_q)
    else $error("crystal pad driven while crystal in use");
  AST_ADC_CLOSE: assert property (
    $rose(adc_sw_close_q[0]) |-> $past(adc_sw_req[0]))
    else $error("ADC switch closed without request");
  AST_I2C_OD: assert property (
    sel_q[0] == pfmux_pkg::ENC_I2C_LO |=> !pad_out_q[0] &&
      pad_oe_q[0] == $past(periph_out.scl_low))
    else $error("I2C pad not open-drain");
  AST_TX_IDLE: assert property (
    power_state_q == pfmux_pkg::ST_SLEEP &&
      sel_q[0] == pfmux_pkg::ENC_UART |=> pad_out_q[0] && pad_oe_q[0])
    else $error("transmit pad not held high in deep sleep");
  AST_PIXCLK_LOW: assert property (
    power_state_q == pfmux_pkg::ST_SLEEP &&
      sel_q[1] == pfmux_pkg::ENC_CAM |=> !pad_out_q[1] && pad_oe_q[1])
    else $error("pixel clock pad not held low in deep sleep");
  AST_UNLISTED: assert property (
    sel_q[3] == pfmux_pkg::ENC_PWM |=> !pad_oe_q[3] &&
      !periph_in_q.gpio_i[3] && !periph_in_q.capture_i[3])
    else $error("unlisted encoding left a path connected");
endmodule

//--- tb/pfmux_board.sv
/*
  board model for pads one to six, the oscillator / boot-mode pad and
  the slow crystal negative pad.
  assumes the bench supplies far-side levels and changes them before every check_all.
*/
`timescale 1ns/100ps
module pfmux_board (
  // design drive
  input wire logic [5:0] pad_out_q,
  input wire logic [5:0] pad_oe_q,
  input wire logic osc_pad_out_q,
  input wire logic osc_pad_oe_q,
  // straps and far-side levels
  input wire logic [5:0] far_lvl,
  input wire logic boot_strap,
  input wire logic xtal_pullup,
  // resolved levels
  output logic [5:0] pad_in,
  output logic osc_pad_in,
  output logic slow_crystal_negative_pad_in
);
  // far side only drives a pad the device has released
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pad_in[p] = pad_oe_q[p] ? pad_out_q[p] : far_lvl[p];
    end
  end
  // device level while driven; else strap resistor outweighs the weak pull-down
  assign osc_pad_in = osc_pad_oe_q ? osc_pad_out_q : boot_strap;
  // pull-up fitted when a square wave feeds the positive pad
  assign slow_crystal_negative_pad_in = xtal_pullup;
endmodule

//--- tb/tb_pad_function_mux_pins_one_to_six.sv
/*
  self-checking bench for the pad function mux with a behavioural model.
  assumes the board model in pfmux_board and the package pfmux_pkg.
*/
`timescale 1ns/100ps
module tb_pad_function_mux_pins_one_to_six;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0][3:0] mux_sel = '0;
  logic deep_sleep_state = 1'b0;
  logic hibernate_mode = 1'b0;
  pfmux_pkg::pfmux_state_t power_state_q;
  pfmux_pkg::pfmux_po_t periph_out = '0;
  pfmux_pkg::pfmux_pi_t periph_in_q;
  logic [5:0] pad_in;
  logic [5:0] pad_out_q;
  logic [5:0] pad_oe_q;
  logic [5:0] far_lvl = '0;
  logic antenna_sel = 1'b0;
  logic [1:0] ant_pad_out_q;
  logic [1:0] ant_pad_oe_q;
  logic osc_pad_in;
  logic osc_pad_out_q;
  logic osc_pad_oe_q;
  logic osc_pad_pd_q;
  logic boot_mode_sense_bit_two_q;
  logic boot_strap = 1'b1;
  logic xtal_pullup = 1'b1;
  logic slow_crystal_negative_pad_in;
  logic xn_gpio_out = 1'b0;
  logic xn_gpio_oe = 1'b0;
  logic slow_clk_ext_q;
  logic xn_pad_out_q;
  logic xn_pad_oe_q;
  logic [3:0] adc_sw_req = '0;
  logic [3:0] adc_sw_close_q;
  int fails = 0;
  int checks = 0;
  int ps = 0;

  pfmux_top pfmux_top_i (.clk, .rst_n, .mux_sel, .deep_sleep_state,
    .hibernate_mode, .power_state_q, .periph_out, .periph_in_q, .pad_in,
    .pad_out_q, .pad_oe_q, .antenna_sel, .ant_pad_out_q, .ant_pad_oe_q,
    .osc_pad_in, .osc_pad_out_q, .osc_pad_oe_q, .osc_pad_pd_q,
    .boot_mode_sense_bit_two_q, .slow_crystal_negative_pad_in,
    .xn_gpio_out, .xn_gpio_oe, .slow_clk_ext_q, .xn_pad_out_q,
    .xn_pad_oe_q, .adc_sw_req, .adc_sw_close_q);

  pfmux_board pfmux_board_i (.pad_out_q, .pad_oe_q, .osc_pad_out_q,
    .osc_pad_oe_q, .far_lvl, .boot_strap, .xtal_pullup, .pad_in,
    .osc_pad_in, .slow_crystal_negative_pad_in);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // expected pad drive; o only meaningful while oe is high
  function automatic void drv(input int p, input logic [3:0] e,
      input pfmux_pkg::pfmux_po_t po, input int st, output logic o,
      output logic oe);
    int k;
    k = p * 16 + int'(e);
    o = 1'b0;
    oe = 1'b0;
    case (k)
      0, 16, 32, 48, 64, 80: begin
        o = po.gpio_o[p];
        oe = po.gpio_oe[p];
      end
      1, 37, 69: oe = po.scl_low;
      17, 53, 85: oe = po.sda_low;
      22: oe = po.card_cmd_oe & ~po.card_cmd_o;
      3: {o, oe} = {po.timer_pwm_out_a, 1'b1};
      6: {o, oe} = {po.card_clock_out, 1'b1};
      7: {o, oe} = {po.second_serial_transmit, 1'b1};
      19: {o, oe} = {po.timer_pwm_out_b, 1'b1};
      20: {o, oe} = {po.camera_pixel_clock_out, 1'b1};
      29: {o, oe} = {po.audio_frame_sync, 1'b1};
      35: {o, oe} = {po.audio_bit_clock, 1'b1};
      39: {o, oe} = {po.first_serial_transmit, 1'b1};
      71: {o, oe} = {po.spi_clk_o, po.spi_clk_oe};
      87: {o, oe} = {po.spi_so_o, po.spi_so_oe};
      88: {o, oe} = {po.card_d0_o, po.card_d0_oe};
      default: ;
    endcase
    if (st == 1 && (k == 7 || k == 39)) begin
      {o, oe} = 2'b11;
    end
    if (st == 1 && (k == 6 || k == 20)) begin
      {o, oe} = 2'b01;
    end
  endfunction

  function automatic pfmux_pkg::pfmux_pi_t exp_pi(
      input logic [5:0][3:0] s, input logic [5:0] lvl);
    pfmux_pkg::pfmux_pi_t r;
    r = '0;
    for (int p = 0; p < 6; p++) begin
      case (p * 16 + int'(s[p]))
        0, 16, 32, 48, 64, 80: r.gpio_i[p] = lvl[p];
        12, 28, 44, 60, 76, 93: r.capture_i[p] = lvl[p];
        1, 37, 69: r.scl_i = r.scl_i | lvl[p];
        17, 53, 85: r.sda_i = r.sda_i | lvl[p];
        22: r.card_cmd_i = lvl[p];
        23: r.second_serial_receive = lvl[p];
        36: r.camera_vertical_sync = lvl[p];
        52: r.camera_horizontal_sync = lvl[p];
        55: r.first_serial_receive = lvl[p];
        68: r.camera_data_bit_four = lvl[p];
        71: r.spi_clk_i = lvl[p];
        84: r.camera_data_bit_five = lvl[p];
        87: r.spi_so_i = lvl[p];
        88: r.card_d0_i = lvl[p];
        default: ;
      endcase
    end
    return r;
  endfunction

  task automatic check_all();
    logic [5:0] eo;
    logic [5:0] eoe;
    logic [5:0] lvl;
    for (int p = 0; p < 6; p++) begin
      drv(p, mux_sel[p], periph_out, ps, eo[p], eoe[p]);
      lvl[p] = eoe[p] ? eo[p] : far_lvl[p];
    end
    cmp("pad_oe", 32'(eoe), 32'(pad_oe_q));
    cmp("pad_out", 32'(eo & eoe), 32'(pad_out_q & eoe));
    cmp("periph_in", 32'(exp_pi(mux_sel, lvl)), 32'(periph_in_q));
  endtask

  task automatic check_reset();
    cmp("pad_oe", 32'h0, 32'(pad_oe_q));
    cmp("osc_oe_pd", 32'h1, 32'({osc_pad_oe_q, osc_pad_pd_q}));
    cmp("adc_sw", 32'h0, 32'(adc_sw_close_q));
  endtask

  initial begin
    void'($urandom(9137));
    step(20);
    check_reset();
    rst_n = 1'b1;
    step(3);
    cmp("osc_drive", 32'h6, 32'({osc_pad_oe_q, osc_pad_out_q,
      osc_pad_pd_q}));
    cmp("boot_bit", 32'h1, 32'(boot_mode_sense_bit_two_q));
    cmp("slow_ext", 32'h1, 32'(slow_clk_ext_q));
    cmp("state", 32'h2, 32'(power_state_q));
    for (int i = 0; i < 12; i++) begin
      antenna_sel = i[0];
      // freed crystal pad used as output only
      xn_gpio_out = 1'($urandom);
      xn_gpio_oe = 1'($urandom);
      adc_sw_req = 4'($urandom);
      step(2);
      cmp("ant", 32'({2'b11, antenna_sel, ~antenna_sel}),
        32'({ant_pad_oe_q, ant_pad_out_q}));
      cmp("xn_oe", 32'(xn_gpio_oe), 32'(xn_pad_oe_q));
      cmp("xn_out", 32'(xn_gpio_out & xn_gpio_oe),
        32'(xn_pad_out_q & xn_gpio_oe));
      cmp("adc_sw", 32'(adc_sw_req), 32'(adc_sw_close_q));
    end
    // hibernate is raised with sleep still held to test priority
    for (ps = 0; ps < 3; ps++) begin
      deep_sleep_state = (ps >= 1);
      hibernate_mode = (ps == 2);
      step(3);
      cmp("state", 32'(4'h2 << ps), 32'(power_state_q));
      if (ps == 2) begin
        cmp("osc_hib", 32'h1, 32'({osc_pad_oe_q, osc_pad_pd_q}));
      end
      for (int k = 0; k < 46; k++) begin
        if (k < 16) begin
          mux_sel = {6{4'(k)}};
        end else begin
          mux_sel = 24'($urandom);
        end
        periph_out = $bits(periph_out)'($urandom);
        far_lvl = 6'($urandom);
        step(4);
        check_all();
      end
    end
    deep_sleep_state = 1'b0;
    hibernate_mode = 1'b0;
    boot_strap = 1'b0;
    xtal_pullup = 1'b0;
    xn_gpio_oe = 1'b1;
    step(2);
    rst_n = 1'b0;
    step(2);
    check_reset();
    rst_n = 1'b1;
    step(3);
    cmp("boot_bit", 32'h0, 32'(boot_mode_sense_bit_two_q));
    cmp("slow_ext", 32'h0, 32'(slow_clk_ext_q));
    cmp("xn_oe", 32'h0, 32'(xn_pad_oe_q));
    print_verdict();
  end

  // run needs under 1000 cycles; ten times that means a hang
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule
